// ===== irq_prio_pkg.sv
/*
  Package for the two-level interrupt priority unit: register map, bit positions,
  reset values, vector addresses and the latency figure.
  Assumes a 32-bit Avalon-MM slave port with word addressing by byte address.
*/
package irq_prio_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] OFS_RESET_CTRL = 5'h00;
  localparam logic [4:0] OFS_MAIN_CTRL = 5'h04;
  localparam logic [4:0] OFS_FLAGS_ONE = 5'h08;
  localparam logic [4:0] OFS_ENABLES_ONE = 5'h0C;
  localparam logic [4:0] OFS_PRIO_ONE = 5'h10;
  localparam logic [4:0] OFS_FLAGS_TWO = 5'h14;
  localparam logic [4:0] OFS_ENABLES_TWO = 5'h18;
  localparam logic [4:0] OFS_PRIO_TWO = 5'h1C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_PRIO_EN = 7;
  localparam int BIT_GIE_HIGH = 7;
  localparam int BIT_GIE_LOW = 6;
  localparam int BIT_EXT_ENABLE = 4;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_SVC_HIGH = 1;
  localparam int BIT_SVC_LOW = 0;
  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MASK_ENABLES_TWO = 8'hDF;
  localparam logic [7:0] MASK_RESET_CTRL = 8'h80;
  // ---------------------------------------------------------------
  // Vectors and timing
  // ---------------------------------------------------------------
  localparam logic [20:0] VEC_HIGH = 21'h000008;
  localparam logic [20:0] VEC_LOW = 21'h000018;
  // Pin event latency: two sync stages plus one flag stage, then vector
  localparam int EXT_LAT_CYCLES = 3;
endpackage : irq_prio_pkg

// ===== two_level_interrupt_priority_unit.sv
/*
  Two-level interrupt priority unit: flags, enables, priorities, global enables,
  vector selection and core handshake (vector take, return).
  Assumes core pulses i_vector_ack when it pushes the return address and jumps,
  and i_return_pulse on the return-from-interrupt instruction.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - High requests vector to 000008h, low requests to 000018h.
// - Enabled high request preempts running low-level service routine.
// - Each peripheral source has flag, enable and priority bits; the pin source has no priority bit and is always high.
// - Two-level scheme only while priority enable bit is set.
// - With priority, high global enable gates high-priority sources.
// - With priority, low global enable gates low-priority sources.
// - Flag, enable and global enable all set vectors by source priority.
// - Priority off after reset; priority bits then ignored.
// - Single-level mode: bit 6 gates peripherals, bit 7 gates everything.
// - Single-level mode vectors every interrupt to 000008h.
// - Accepting an interrupt clears the global enable that admitted it.
// - Low requests held off while high routine runs.
// - Vectoring pushes return address and loads vector into PC.
// - Return instruction sets the applicable global enable again.
// - Pin events reach the vector in three to four cycles.
// - Flags set on event regardless of any enable.
module two_level_interrupt_priority_unit
  import irq_prio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_periph_event_one,
  input wire logic [7:0] i_periph_event_two,
  input wire logic i_ext_pin_event,
  input wire logic i_vector_ack,
  input wire logic i_return_pulse,
  output logic o_irq_request,
  output logic [20:0] o_vector_addr,
  output logic o_push_return
);

  typedef struct packed {
    logic prio_en;
    logic [7:0] main_ctrl;
    logic [7:0] flags_one;
    logic [7:0] enables_one;
    logic [7:0] prio_one;
    logic [7:0] flags_two;
    logic [7:0] enables_two;
    logic [7:0] prio_two;
    logic svc_high;
    logic svc_low;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [31:0] rdata;
    logic wait_n;
    logic wreq;
    logic irq;
    logic [20:0] vec;
    logic push;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [7:0] hi_sel_one;
  logic [7:0] hi_sel_two;
  logic any_periph;
  logic any_core;
  logic req_high;
  logic req_low;
  logic want_high;
  logic want_low;
  logic take;
  logic [31:0] rd_mux;
  logic [7:0] wbyte;
  logic wr_go;

  // ---------------------------------------------------------------
  // Request formation
  // ---------------------------------------------------------------
  always_comb begin
    // Priority bits only matter with the scheme on
    hi_sel_one = st_reg.prio_en ? st_reg.prio_one : 8'hFF;
    hi_sel_two = st_reg.prio_en ? st_reg.prio_two : 8'hFF;
    any_periph = |(st_reg.flags_one & st_reg.enables_one) |
                 |(st_reg.flags_two & st_reg.enables_two);
    any_core = st_reg.main_ctrl[BIT_EXT_FLAG] & st_reg.main_ctrl[BIT_EXT_ENABLE];
    req_high = |(st_reg.flags_one & st_reg.enables_one & hi_sel_one) |
               |(st_reg.flags_two & st_reg.enables_two & hi_sel_two) | any_core;
    req_low = |(st_reg.flags_one & st_reg.enables_one & ~st_reg.prio_one) |
              |(st_reg.flags_two & st_reg.enables_two & ~st_reg.prio_two);
    if (st_reg.prio_en) begin
      want_high = req_high & st_reg.main_ctrl[BIT_GIE_HIGH];
      want_low = req_low & st_reg.main_ctrl[BIT_GIE_LOW] & ~st_reg.svc_high;
    end else begin
      // Single enable gates all, group enable gates peripherals
      want_high = st_reg.main_ctrl[BIT_GIE_HIGH] &
                  (any_core | (any_periph & st_reg.main_ctrl[BIT_GIE_LOW]));
      want_low = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  always_comb begin
    wbyte = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;
    // Write lands on the edge where waitrequest is seen low
    wr_go = i_avs_write & st_reg.wait_n & i_avs_byteenable[0];
    take = i_vector_ack & st_reg.irq;
    case (i_avs_address)
      OFS_RESET_CTRL: rd_mux = {24'h000000, st_reg.prio_en, 7'h00};
      OFS_MAIN_CTRL: rd_mux = {24'h000000, st_reg.main_ctrl};
      OFS_FLAGS_ONE: rd_mux = {24'h000000, st_reg.flags_one};
      OFS_ENABLES_ONE: rd_mux = {24'h000000, st_reg.enables_one};
      OFS_PRIO_ONE: rd_mux = {24'h000000, st_reg.prio_one};
      OFS_FLAGS_TWO: rd_mux = {24'h000000, st_reg.flags_two};
      OFS_ENABLES_TWO: rd_mux = {24'h000000, st_reg.enables_two};
      OFS_PRIO_TWO: rd_mux = {24'h000000, st_reg.prio_two};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Pin event: two sync stages, then edge detect on the second and third
    st_next.ext_s1 = i_ext_pin_event;
    st_next.ext_s2 = st_reg.ext_s1;
    st_next.ext_s3 = st_reg.ext_s2;
    // One wait state per access; answer on the second edge
    st_next.wait_n = (i_avs_read | i_avs_write) & ~st_reg.wait_n;
    st_next.wreq = ~st_next.wait_n;
    st_next.rdata = (i_avs_read & ~st_reg.wait_n) ? rd_mux : st_reg.rdata;
    if (wr_go) begin
      case (i_avs_address)
        OFS_RESET_CTRL: st_next.prio_en = wbyte[BIT_PRIO_EN];
        OFS_MAIN_CTRL: st_next.main_ctrl = wbyte;
        OFS_FLAGS_ONE: st_next.flags_one = wbyte;
        OFS_ENABLES_ONE: st_next.enables_one = wbyte;
        OFS_PRIO_ONE: st_next.prio_one = wbyte;
        OFS_FLAGS_TWO: st_next.flags_two = wbyte;
        OFS_ENABLES_TWO: st_next.enables_two = wbyte & MASK_ENABLES_TWO;
        OFS_PRIO_TWO: st_next.prio_two = wbyte;
        default: st_next.wait_n = st_next.wait_n;
      endcase
    end
    // Events set after the write so a set beats a same-cycle clear
    st_next.flags_one = st_next.flags_one | i_periph_event_one;
    st_next.flags_two = st_next.flags_two | (i_periph_event_two & MASK_ENABLES_TWO);
    if (st_reg.ext_s2 & ~st_reg.ext_s3) begin
      st_next.main_ctrl[BIT_EXT_FLAG] = 1'b1;
    end
    // Vector accepted by the core
    if (take) begin
      if (st_reg.vec == VEC_HIGH) begin
        st_next.main_ctrl[BIT_GIE_HIGH] = 1'b0;
        st_next.svc_high = st_reg.prio_en;
      end else begin
        st_next.main_ctrl[BIT_GIE_LOW] = 1'b0;
        st_next.svc_low = 1'b1;
      end
    end else if (i_return_pulse) begin
      // Innermost routine returns first: high nests inside low
      if (!st_reg.prio_en || st_reg.svc_high || !st_reg.svc_low) begin
        st_next.main_ctrl[BIT_GIE_HIGH] = 1'b1;
        st_next.svc_high = 1'b0;
      end else begin
        st_next.main_ctrl[BIT_GIE_LOW] = 1'b1;
        st_next.svc_low = 1'b0;
      end
    end
    // Request out; high wins and can preempt a low routine
    if (take) begin
      st_next.irq = 1'b0;
    end else if (want_high) begin
      st_next.irq = 1'b1;
      st_next.vec = VEC_HIGH;
    end else if (want_low) begin
      st_next.irq = 1'b1;
      st_next.vec = VEC_LOW;
    end else begin
      st_next.irq = 1'b0;
    end
    st_next.push = take;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
      st_reg.vec <= VEC_HIGH;
      st_reg.wreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.wreq;
  assign o_irq_request = st_reg.irq;
  assign o_vector_addr = st_reg.vec;
  assign o_push_return = st_reg.push;

endmodule : two_level_interrupt_priority_unit
`default_nettype wire

// ===== irq_prio_monitor.sv
/* Port checker for the interrupt priority unit.
   Assumes one clock and a bind onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module irq_prio_monitor
  import irq_prio_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_vector_ack,
  input wire logic o_irq_request,
  input wire logic [20:0] o_vector_addr,
  input wire logic o_push_return
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_vec_legal: assert property (o_vector_addr == VEC_HIGH || o_vector_addr == VEC_LOW)
    else $error("bad vector");
  chk_push_after_ack: assert property (i_vector_ack && o_irq_request |=> o_push_return)
    else $error("no push");
  chk_push_cause: assert property (o_push_return |-> $past(i_vector_ack && o_irq_request))
    else $error("stray push");
  chk_push_single: assert property (o_push_return |=> !o_push_return)
    else $error("long push");
  chk_ack_drops_irq: assert property (i_vector_ack && o_irq_request |=> !o_irq_request)
    else $error("irq held");
  chk_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer");
  chk_bus_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("long answer");
  chk_rdata_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("upper bits");
  cover property (o_push_return && o_vector_addr == VEC_LOW);
  cover property (o_push_return && o_vector_addr == VEC_HIGH);
  cover property ($rose(o_irq_request));
endmodule : irq_prio_monitor
bind two_level_interrupt_priority_unit irq_prio_monitor u_mon (.*);
`default_nettype wire

// ===== irq_core_model.sv
/* Core model: takes the vector after a set wait.
   Assumes the request is a level held until taken. */
`timescale 1ns/1ps
`default_nettype none
module irq_core_model #(
  parameter int ACK_DELAY = 2
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_irq,
  input wire logic [20:0] i_vec,
  output logic o_ack,
  output logic [20:0] o_last_vec,
  output int o_taken
);
  int wait_cnt;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      o_last_vec <= 21'h000000;
      o_taken <= 0;
      wait_cnt <= 0;
    end else if (i_irq && !o_ack && wait_cnt == ACK_DELAY) begin
      o_ack <= 1'b1;
      o_last_vec <= i_vec;
      o_taken <= o_taken + 1;
      wait_cnt <= 0;
    end else begin
      // Wait restarts if the request goes away
      o_ack <= 1'b0;
      wait_cnt <= i_irq ? wait_cnt + 1 : 0;
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ===== two_level_interrupt_priority_unit_test.sv
/* Bench for the interrupt priority unit over its Avalon-MM port.
   Assumes the core model acks every request. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t mismatch", $time); end end
module two_level_interrupt_priority_unit_test
  import irq_prio_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [7:0] ev_one = 8'h00;
  logic [7:0] ev_two = 8'h00;
  logic pin = 1'b0;
  logic ret = 1'b0;
  logic [31:0] rdata;
  logic [7:0] q;
  logic wreq, irq, ack, push;
  logic [20:0] vec, last_vec;
  int taken, n_fail, checked, ntk, n;
  two_level_interrupt_priority_unit u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_periph_event_one(ev_one), .i_periph_event_two(ev_two),
    .i_ext_pin_event(pin), .i_vector_ack(ack), .i_return_pulse(ret),
    .o_irq_request(irq), .o_vector_addr(vec), .o_push_return(push));
  irq_core_model u_core (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_irq(irq), .i_vec(vec),
    .o_ack(ack), .o_last_vec(last_vec), .o_taken(taken));
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {24'h000000, d};
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : acc
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask : rc
  task automatic tk(input logic [20:0] v);
    ntk++;
    repeat (50) if (taken < ntk) @(posedge i_clk);
    `CHK(last_vec, v)
    @(posedge i_clk);
    `CHK(push, 1'b1)
  endtask : tk
  task automatic pulse(input logic [7:0] m, input logic r);
    @(posedge i_clk);
    ev_one <= m;
    ret <= r;
    @(posedge i_clk);
    ev_one <= 8'h00;
    ret <= 1'b0;
  endtask : pulse
  task automatic quiet();
    repeat (4) @(posedge i_clk);
    `CHK(irq, 1'b0)
  endtask : quiet
  task automatic stop_test();
    $display("n_fail=%0d checked=%0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  initial forever #25 i_clk = ~i_clk;
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rc(OFS_ENABLES_TWO, 8'h00);
    rc(OFS_RESET_CTRL, 8'h00);
    acc(1'b1, OFS_ENABLES_TWO, 8'hFF);
    rc(OFS_ENABLES_TWO, 8'hDF);
    pulse(8'h01, 1'b0);
    rc(OFS_FLAGS_ONE, 8'h01);
    quiet();
    acc(1'b1, OFS_ENABLES_ONE, 8'h03);
    acc(1'b1, OFS_PRIO_ONE, 8'h02);
    acc(1'b1, OFS_MAIN_CTRL, 8'h80);
    quiet();
    acc(1'b1, OFS_MAIN_CTRL, 8'hC0);
    tk(VEC_HIGH);
    rc(OFS_MAIN_CTRL, 8'h40);
    acc(1'b1, OFS_FLAGS_ONE, 8'h00);
    pulse(8'h00, 1'b1);
    rc(OFS_MAIN_CTRL, 8'hC0);
    acc(1'b1, OFS_MAIN_CTRL, 8'h80);
    acc(1'b1, OFS_RESET_CTRL, 8'h80);
    pulse(8'h01, 1'b0);
    quiet();
    acc(1'b1, OFS_MAIN_CTRL, 8'hC0);
    tk(VEC_LOW);
    rc(OFS_MAIN_CTRL, 8'h80);
    pulse(8'h02, 1'b0);
    tk(VEC_HIGH);
    rc(OFS_MAIN_CTRL, 8'h00);
    acc(1'b1, OFS_MAIN_CTRL, 8'h40);
    quiet();
    acc(1'b1, OFS_FLAGS_ONE, 8'h00);
    pulse(8'h00, 1'b1);
    rc(OFS_MAIN_CTRL, 8'hC0);
    acc(1'b1, OFS_MAIN_CTRL, 8'hD0);
    @(posedge i_clk);
    pin <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK(n >= EXT_LAT_CYCLES && n <= EXT_LAT_CYCLES + 1, 1'b1)
    tk(VEC_HIGH);
    rc(OFS_MAIN_CTRL, 8'h52);
    stop_test();
  end
endmodule : two_level_interrupt_priority_unit_test
`default_nettype wire
